// ===== rtl/fsle_encoder.sv
/*
 * Fieldbus status LED encoder: duo fault LED, per-port link and activity LEDs,
 * and a small register port for firmware.
 * Assumes firmware on the same clock drives the register port; LED pins are plain outputs.
 */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - System fault lights green only, steadily.
// - No config or bad link: steady red.
// - No data exchange: red flashes at 2 Hz.
// - Signal request: green blinks 1 Hz, 3 s.
// - Signal with no exchange: orange-green-red-dark cycle.
// - Signal with config/link fault: orange, red alternate.
// - Fault with no exchange: orange/green at 2 Hz.
// - Same condition may instead show steady orange.
// - Orange drives red and green together.
// - Port link LED follows port link.
// - Heavy traffic flickers activity near 10 Hz.
// - Light traffic flashes follow actual frames.
// - Activity LED dark without frames.
module fsle_encoder #(
    parameter int TICK_CYCLES = fsle_pkg::BASE_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [fsle_pkg::ADDR_WIDTH-1:0] address,
    input wire logic [fsle_pkg::DATA_WIDTH-1:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [fsle_pkg::DATA_WIDTH-1:0] read_data,
    input wire logic [1:0] port_link_pin,
    input wire logic [1:0] port_frame_pin,
    output fsle_pkg::fsle_duo_s fault_duo_indicator,
    output fsle_pkg::fsle_port_s [1:0] port_leds
);

    localparam logic [fsle_pkg::TICK_COUNT_WIDTH-1:0] TICK_LAST =
        fsle_pkg::TICK_COUNT_WIDTH'(TICK_CYCLES - 1);
    localparam logic [fsle_pkg::PHASE_WIDTH-1:0] PHASE_LAST =
        fsle_pkg::PHASE_WIDTH'(fsle_pkg::CYCLE_TICKS - 1);
    localparam logic [fsle_pkg::SIGNAL_WIDTH-1:0] SIGNAL_LOAD =
        fsle_pkg::SIGNAL_WIDTH'(fsle_pkg::SIGNAL_TICKS);

    fsle_pkg::fsle_core_s state;
    fsle_pkg::fsle_core_s next_state;
    logic tick;
    logic signal_active;
    logic sys_fault;
    logic link_fault;
    logic no_exchange;
    logic signal_write;
    logic [1:0] quarter_now;

    // ----------------------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------------------
    function automatic logic [1:0] quarter_of(input logic [fsle_pkg::PHASE_WIDTH-1:0] phase);
        return 2'(phase / fsle_pkg::PHASE_WIDTH'(fsle_pkg::QUARTER_TICKS));
    endfunction

    function automatic logic half_of(input logic [fsle_pkg::PHASE_WIDTH-1:0] phase);
        return phase >= fsle_pkg::PHASE_WIDTH'(fsle_pkg::HALF_TICKS);
    endfunction

    // Orange is both elements lit at once.
    function automatic fsle_pkg::fsle_duo_s duo_of(input fsle_pkg::fsle_pattern_e pattern,
                                                   input logic [fsle_pkg::PHASE_WIDTH-1:0] phase);
        fsle_pkg::fsle_duo_s duo;
        logic [1:0] quarter;
        duo = '0;
        quarter = quarter_of(phase);
        unique case (pattern)
            fsle_pkg::PAT_OFF: duo = '0;
            fsle_pkg::PAT_GREEN: duo.system_fault_green = 1'b1;
            fsle_pkg::PAT_RED: duo.bus_fault_red = 1'b1;
            fsle_pkg::PAT_ORANGE: duo = '1;
            fsle_pkg::PAT_FLASH1: duo.system_fault_green = !half_of(phase);
            fsle_pkg::PAT_FLASH2: duo.bus_fault_red = !quarter[0];
            fsle_pkg::PAT_FLASH3: begin
                duo.system_fault_green = (quarter == 2'd0) || (quarter == 2'd1);
                duo.bus_fault_red = (quarter == 2'd0) || (quarter == 2'd2);
            end
            fsle_pkg::PAT_FLASH4: begin
                duo.bus_fault_red = 1'b1;
                duo.system_fault_green = !half_of(phase);
            end
            fsle_pkg::PAT_FLASH5: begin
                duo.system_fault_green = 1'b1;
                duo.bus_fault_red = !quarter[0];
            end
            default: duo = '0;
        endcase
        return duo;
    endfunction

    // ----------------------------------------------------------------------------
    // Ports
    // ----------------------------------------------------------------------------
    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            fsle_port_indicator u_port (
                .clock(clock),
                .reset(reset),
                .tick(tick),
                .link_pin(port_link_pin[p]),
                .frame_pin(port_frame_pin[p]),
                .leds(port_leds[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------------------
    // Condition summary
    // ----------------------------------------------------------------------------
    assign tick = (state.tick_count == TICK_LAST);
    assign quarter_now = quarter_of(state.phase);
    assign signal_active = (state.signal_left != '0);
    assign sys_fault = state.condition[fsle_pkg::COND_WATCHDOG] || state.condition[fsle_pkg::COND_DIAGNOSIS]
        || state.condition[fsle_pkg::COND_SYSTEM_ERROR];
    assign link_fault = state.condition[fsle_pkg::COND_NO_CONFIG] || state.condition[fsle_pkg::COND_LOW_SPEED]
        || !(port_leds[0].link || port_leds[1].link);
    assign no_exchange = state.condition[fsle_pkg::COND_NO_DATA_EXCHANGE];
    assign signal_write = write_strobe && (address == fsle_pkg::REG_SIGNAL)
        && write_data[fsle_pkg::SIGNAL_TRIGGER];

    // ----------------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (tick) begin
            next_state.tick_count = '0;
            next_state.phase = (state.phase == PHASE_LAST) ? '0 : state.phase + 1'b1;
            if (signal_active) begin
                next_state.signal_left = state.signal_left - 1'b1;
            end
        end else begin
            next_state.tick_count = state.tick_count + 1'b1;
        end
        // A signal request restarts the pattern at its first colour for a full 3 s.
        if (signal_write) begin
            next_state.tick_count = '0;
            next_state.phase = '0;
            next_state.signal_left = SIGNAL_LOAD;
        end
        if (write_strobe && address == fsle_pkg::REG_CONDITION) begin
            next_state.condition = write_data[fsle_pkg::COND_WIDTH-1:0];
        end

        // Priority: signal overlays first, then system fault, link, exchange.
        if (signal_active && no_exchange) begin
            next_state.pattern = fsle_pkg::PAT_FLASH3;
        end else if (signal_active && link_fault) begin
            next_state.pattern = fsle_pkg::PAT_FLASH4;
        end else if (signal_active) begin
            next_state.pattern = fsle_pkg::PAT_FLASH1;
        end else if (sys_fault && no_exchange) begin
            next_state.pattern = state.condition[fsle_pkg::COND_ORANGE_STEADY]
                ? fsle_pkg::PAT_ORANGE : fsle_pkg::PAT_FLASH5;
        end else if (sys_fault) begin
            next_state.pattern = fsle_pkg::PAT_GREEN;
        end else if (link_fault) begin
            next_state.pattern = fsle_pkg::PAT_RED;
        end else if (no_exchange) begin
            next_state.pattern = fsle_pkg::PAT_FLASH2;
        end else begin
            next_state.pattern = fsle_pkg::PAT_OFF;
        end
        next_state.duo = duo_of(state.pattern, state.phase);

        next_state.read_data = '0;
        if (read_strobe) begin
            unique case (address)
                fsle_pkg::REG_CONDITION: begin
                    next_state.read_data[fsle_pkg::COND_WIDTH-1:0] = state.condition;
                end
                fsle_pkg::REG_SIGNAL: begin
                    next_state.read_data[fsle_pkg::SIGNAL_TRIGGER] = signal_active;
                end
                fsle_pkg::REG_STATUS: begin
                    next_state.read_data[fsle_pkg::STATUS_RED] = state.duo.bus_fault_red;
                    next_state.read_data[fsle_pkg::STATUS_GREEN] = state.duo.system_fault_green;
                    next_state.read_data[fsle_pkg::STATUS_PORT_BASE +: 4] = port_leds;
                    next_state.read_data[fsle_pkg::STATUS_PATTERN +: 4] = state.pattern;
                    next_state.read_data[fsle_pkg::STATUS_SIGNAL_ACTIVE] = signal_active;
                end
                default: next_state.read_data = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign read_data = state.read_data;
    assign fault_duo_indicator = state.duo;

    // ----------------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------------
    default clocking core_clk @(posedge clock); endclocking
    default disable iff (reset);

    AST_FAULT_GREEN: assert property (
        (sys_fault && !no_exchange && !signal_active && !signal_write) [*2]
        |=> fault_duo_indicator.system_fault_green && !fault_duo_indicator.bus_fault_red)
        else $error("System fault did not give steady green.");
    AST_LINK_RED: assert property (
        (link_fault && !sys_fault && !signal_active && !signal_write) [*2]
        |=> fault_duo_indicator.bus_fault_red && !fault_duo_indicator.system_fault_green)
        else $error("Configuration or link fault did not give steady red.");
    AST_FLASH2_PHASE: assert property (
        (state.pattern == fsle_pkg::PAT_FLASH2)
        |=> fault_duo_indicator.bus_fault_red == !$past(quarter_now[0])
            && !fault_duo_indicator.system_fault_green)
        else $error("Red 2 Hz flash out of phase.");
    AST_SIGNAL_SPAN: assert property (
        signal_write |=> state.signal_left == SIGNAL_LOAD && state.phase == '0)
        else $error("Signal request did not start a full window.");
    AST_FLASH3_DARK: assert property (
        (state.pattern == fsle_pkg::PAT_FLASH3 && quarter_now == 2'd3) |=> fault_duo_indicator == '0)
        else $error("Fourth quarter of the signal cycle not dark.");
    AST_FLASH4_RED: assert property (
        (state.pattern == fsle_pkg::PAT_FLASH4 && half_of(state.phase))
        |=> fault_duo_indicator.bus_fault_red && !fault_duo_indicator.system_fault_green)
        else $error("Second half of orange/red alternation not red.");
    AST_FLASH5_GREEN: assert property (
        (state.pattern == fsle_pkg::PAT_FLASH5 && quarter_now[0])
        |=> !fault_duo_indicator.bus_fault_red && fault_duo_indicator.system_fault_green)
        else $error("Odd quarter of orange/green alternation not green.");
    AST_ORANGE_BOTH: assert property (
        (state.pattern == fsle_pkg::PAT_ORANGE)
        |=> fault_duo_indicator.bus_fault_red && fault_duo_indicator.system_fault_green)
        else $error("Orange did not light both elements.");
    AST_IDLE_DARK: assert property (
        (!sys_fault && !link_fault && !no_exchange && !signal_active && !signal_write) [*2]
        |=> fault_duo_indicator == '0)
        else $error("Duo LED lit without any condition.");
    AST_SIGNAL_PRIORITY: assert property (
        (signal_active && no_exchange) |=> state.pattern == fsle_pkg::PAT_FLASH3)
        else $error("Signal overlay lost priority.");

    COV_SIGNAL_FLASH1: cover property (state.pattern == fsle_pkg::PAT_FLASH1 ##1 state.pattern == fsle_pkg::PAT_OFF);
    COV_SIGNAL_FLASH3: cover property (state.pattern == fsle_pkg::PAT_FLASH3);
    COV_FLASH5: cover property (state.pattern == fsle_pkg::PAT_FLASH5);
    COV_PORT_ACTIVITY: cover property (port_leds[0].activity && port_leds[1].link);

endmodule

`default_nettype wire

// ===== rtl/fsle_pkg.sv
/*
 * Constants, types and timing for the fieldbus status LED encoder.
 * Assumes a 50 MHz system clock; every timebase is a whole number of 50 ms ticks.
 */
package fsle_pkg;

    // ----------------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int BASE_TICK_MS = 50;
    localparam int BASE_TICK_CYCLES = BASE_TICK_MS * 1_000_000 / CLOCK_PERIOD_NS;
    localparam int QUARTER_MS = 250;
    localparam int HALF_MS = 500;
    localparam int CYCLE_MS = 1000;
    localparam int SIGNAL_SPAN_MS = 3000;
    localparam int QUARTER_TICKS = QUARTER_MS / BASE_TICK_MS;
    localparam int HALF_TICKS = HALF_MS / BASE_TICK_MS;
    localparam int CYCLE_TICKS = CYCLE_MS / BASE_TICK_MS;
    localparam int SIGNAL_TICKS = SIGNAL_SPAN_MS / BASE_TICK_MS;
    localparam int TICK_COUNT_WIDTH = 22;
    localparam int PHASE_WIDTH = 5;
    localparam int SIGNAL_WIDTH = 6;

    // ----------------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------------
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam logic [7:0] REG_CONDITION = 8'h00;
    localparam logic [7:0] REG_SIGNAL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [6:0] CONDITION_RESET = 7'h00;
    localparam int COND_WATCHDOG = 0;
    localparam int COND_DIAGNOSIS = 1;
    localparam int COND_SYSTEM_ERROR = 2;
    localparam int COND_NO_CONFIG = 3;
    localparam int COND_LOW_SPEED = 4;
    localparam int COND_NO_DATA_EXCHANGE = 5;
    localparam int COND_ORANGE_STEADY = 6;
    localparam int COND_WIDTH = 7;
    localparam int SIGNAL_TRIGGER = 0;
    localparam int STATUS_RED = 0;
    localparam int STATUS_GREEN = 1;
    localparam int STATUS_PORT_BASE = 2;
    localparam int STATUS_PATTERN = 8;
    localparam int STATUS_SIGNAL_ACTIVE = 12;

    // ----------------------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------------------
    typedef enum logic [3:0] {
        PAT_OFF,
        PAT_GREEN,
        PAT_RED,
        PAT_ORANGE,
        PAT_FLASH1,
        PAT_FLASH2,
        PAT_FLASH3,
        PAT_FLASH4,
        PAT_FLASH5
    } fsle_pattern_e;

    typedef enum logic [1:0] {
        ACT_IDLE,
        ACT_ON,
        ACT_OFF
    } fsle_act_e;

    typedef struct packed {
        logic bus_fault_red;
        logic system_fault_green;
    } fsle_duo_s;

    typedef struct packed {
        logic link;
        logic activity;
    } fsle_port_s;

    typedef struct packed {
        logic link_meta;
        logic link_sync;
        logic frame_meta;
        logic frame_sync;
        logic pending;
        fsle_act_e mode;
        fsle_port_s leds;
    } fsle_port_state_s;

    typedef struct packed {
        logic [TICK_COUNT_WIDTH-1:0] tick_count;
        logic [PHASE_WIDTH-1:0] phase;
        logic [SIGNAL_WIDTH-1:0] signal_left;
        logic [COND_WIDTH-1:0] condition;
        fsle_pattern_e pattern;
        fsle_duo_s duo;
        logic [DATA_WIDTH-1:0] read_data;
    } fsle_core_s;

endpackage

// ===== rtl/fsle_port_indicator.sv
/*
 * Link and activity LEDs of one Ethernet port.
 * Assumes link and frame pins are asynchronous and a one-cycle 50 ms tick from the core.
 */
`timescale 1ns/1ns
`default_nettype none

module fsle_port_indicator (
    input wire logic clock,
    input wire logic reset,
    input wire logic tick,
    input wire logic link_pin,
    input wire logic frame_pin,
    output fsle_pkg::fsle_port_s leds
);

    fsle_pkg::fsle_port_state_s state;
    fsle_pkg::fsle_port_state_s next_state;

    // ----------------------------------------------------------------------------
    // Activity flash: each flash is one tick on and one tick off, so heavy traffic
    // runs at 10 Hz and light traffic flashes only when frames are seen.
    // ----------------------------------------------------------------------------
    always_comb begin
        logic taken;
        taken = 1'b0;
        next_state = state;
        next_state.link_meta = link_pin;
        next_state.link_sync = state.link_meta;
        next_state.frame_meta = frame_pin;
        next_state.frame_sync = state.frame_meta;
        next_state.leds.link = state.link_sync;
        unique case (state.mode)
            fsle_pkg::ACT_IDLE: begin
                if (tick && state.pending) begin
                    taken = 1'b1;
                    next_state.mode = fsle_pkg::ACT_ON;
                end
            end
            fsle_pkg::ACT_ON: begin
                if (tick) begin
                    next_state.mode = fsle_pkg::ACT_OFF;
                end
            end
            fsle_pkg::ACT_OFF: begin
                if (tick) begin
                    taken = state.pending;
                    next_state.mode = state.pending ? fsle_pkg::ACT_ON : fsle_pkg::ACT_IDLE;
                end
            end
            default: begin
                next_state.mode = fsle_pkg::ACT_IDLE;
            end
        endcase
        // A frame seen in the cycle its request is consumed is kept.
        next_state.pending = (state.pending && !taken) || state.frame_sync;
        next_state.leds.activity = (next_state.mode == fsle_pkg::ACT_ON);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign leds = state.leds;

    // ----------------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------------
    default clocking port_clk @(posedge clock); endclocking
    default disable iff (reset);

    AST_LINK_FOLLOWS: assert property (state.link_sync |=> leds.link)
        else $error("Link LED did not follow the link.");
    AST_ACT_DARK_WITHOUT_FRAMES: assert property (
        (state.mode == fsle_pkg::ACT_IDLE && !state.pending && !state.frame_sync) |=> !leds.activity)
        else $error("Activity LED lit without frames.");
    AST_ACT_ON_HOLDS: assert property ((leds.activity && !tick) |=> leds.activity)
        else $error("Activity flash ended before its tick.");
    AST_ACT_OFF_GAP: assert property ($fell(leds.activity) |=> !leds.activity)
        else $error("Activity LED relit without an off phase.");

endmodule

`default_nettype wire

// ===== test/fsle_led_board.sv
/*
 * Board-side model of the status LEDs: measures how long each duo colour
 * and each activity flash stays lit.
 * Assumes the LED outputs of the encoder are wired straight to it.
 */
`timescale 1ns/1ns
`default_nettype none

module fsle_led_board (
    input wire logic clock,
    input wire fsle_pkg::fsle_duo_s duo,
    input wire fsle_pkg::fsle_port_s [1:0] leds,
    output int duo_run,
    output int act_run [2]
);
    logic [1:0] duo_prev;
    int run;
    int act_on [2];

    // A lamp shows only what it is driven with; lengths are in clock cycles.
    always @(posedge clock) begin
        if (duo !== duo_prev) begin
            duo_run <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
        duo_prev <= duo;
        for (int p = 0; p < 2; p++) begin
            if (leds[p].activity === 1'b1) begin
                act_on[p] <= act_on[p] + 1;
            end else begin
                if (act_on[p] != 0) begin
                    act_run[p] <= act_on[p];
                end
                act_on[p] <= 0;
            end
        end
    end
endmodule

`default_nettype wire

// ===== test/test_fsle_encoder.sv
/*
 * Self-checking bench of the status LED encoder with a board LED model.
 * Assumes a tick of 4 clocks, so a quarter is 20 cycles and a half 40.
 */
`timescale 1ns/1ns
`default_nettype none

module test_fsle_encoder;
    localparam logic [31:0] WD = 32'h0000_0001 << fsle_pkg::COND_WATCHDOG;
    localparam logic [31:0] DG = 32'h0000_0001 << fsle_pkg::COND_DIAGNOSIS;
    localparam logic [31:0] SE = 32'h0000_0001 << fsle_pkg::COND_SYSTEM_ERROR;
    localparam logic [31:0] NC = 32'h0000_0001 << fsle_pkg::COND_NO_CONFIG;
    localparam logic [31:0] LS = 32'h0000_0001 << fsle_pkg::COND_LOW_SPEED;
    localparam logic [31:0] ND = 32'h0000_0001 << fsle_pkg::COND_NO_DATA_EXCHANGE;
    localparam logic [31:0] OS = 32'h0000_0001 << fsle_pkg::COND_ORANGE_STEADY;
    logic clock = 0;
    logic reset;
    logic [7:0] address;
    logic [31:0] write_data;
    logic write_strobe;
    logic read_strobe;
    logic [31:0] read_data;
    logic [1:0] port_link_pin;
    logic [1:0] port_frame_pin;
    fsle_pkg::fsle_duo_s duo;
    fsle_pkg::fsle_port_s [1:0] port_leds;
    int duo_run;
    int act_run [2];
    int errors = 0;
    int samples_checked = 0;
    int cnt [4];
    int ac [2];
    logic [31:0] sm [8] = '{WD, DG, SE, NC, LS, SE | NC, SE | ND | OS, 0};
    logic [1:0] se [8] = '{1, 1, 1, 2, 2, 1, 3, 0};
    logic [31:0] gc [3] = '{0, ND, NC};
    logic [7:0] gq [3] = '{8'h50, 8'hD8, 8'hFA};
    int gr [3] = '{40, 20, 40};
    int gx [3] = '{0, 2, 2};
    int gn [3] = '{40, 20, 40};

    always #10 clock = ~clock;

    fsle_encoder #(.TICK_CYCLES(4)) DUT (.clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .port_link_pin(port_link_pin), .port_frame_pin(port_frame_pin),
        .fault_duo_indicator(duo), .port_leds(port_leds));
    fsle_led_board board (.clock(clock), .duo(duo), .leds(port_leds), .duo_run(duo_run), .act_run(act_run));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        write_strobe <= 1;
        address <= a;
        write_data <= d;
        @(posedge clock);
        write_strobe <= 0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        read_strobe <= 1;
        address <= a;
        @(posedge clock);
        read_strobe <= 0;
        #1 check(read_data, exp);
    endtask

    // Counts cycles of each duo colour and of each lit activity LED.
    task automatic census(input int n);
        cnt = '{default: 0};
        ac = '{default: 0};
        repeat (n) begin
            @(posedge clock);
            #1 cnt[duo]++;
            for (int p = 0; p < 2; p++) begin
                ac[p] += int'(port_leds[p].activity);
            end
        end
    endtask

    task automatic test_done;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        errors++;
        test_done;
    end

    initial begin
        reset = 1;
        address = 0;
        write_data = 0;
        write_strobe = 0;
        read_strobe = 0;
        port_link_pin = 2'b11;
        port_frame_pin = 2'b00;
        repeat (3) @(posedge clock);
        reset <= 0;
        rd(fsle_pkg::REG_CONDITION, 0);
        rd(8'h10, 0);
        for (int i = 0; i < 8; i++) begin
            wr(fsle_pkg::REG_CONDITION, sm[i]);
            repeat (6) @(posedge clock);
            census(80);
            check(cnt[se[i]], 80);
        end
        wr(fsle_pkg::REG_CONDITION, NC);
        wr(8'h10, 0);
        rd(fsle_pkg::REG_CONDITION, NC);
        repeat (6) @(posedge clock);
        rd(fsle_pkg::REG_STATUS, 32'h0000_0229);
        wr(fsle_pkg::REG_CONDITION, ND);
        repeat (6) @(posedge clock);
        census(80);
        check(cnt[2], 40);
        check(duo_run, 20);
        wr(fsle_pkg::REG_CONDITION, SE | ND);
        repeat (6) @(posedge clock);
        census(80);
        check(cnt[3], 40);
        check(cnt[1], 40);
        for (int i = 0; i < 3; i++) begin
            wr(fsle_pkg::REG_CONDITION, gc[i]);
            wr(fsle_pkg::REG_SIGNAL, 1);
            repeat (10) @(posedge clock);
            for (int q = 0; q < 4; q++) begin
                #1 check(duo, gq[i][7-2*q -: 2]);
                repeat (20) @(posedge clock);
            end
            check(duo_run, gr[i]);
            rd(fsle_pkg::REG_SIGNAL, 1);
            repeat (188) @(posedge clock);
            census(40);
            check(cnt[gx[i]], gn[i]);
        end
        port_link_pin <= 2'b01;
        repeat (6) @(posedge clock);
        check(port_leds[0].link, 1);
        check(port_leds[1].link, 0);
        wr(fsle_pkg::REG_CONDITION, 0);
        port_link_pin <= 2'b00;
        repeat (6) @(posedge clock);
        census(40);
        check(cnt[2], 40);
        port_link_pin <= 2'b11;
        port_frame_pin <= 2'b10;
        repeat (3) @(posedge clock);
        port_frame_pin <= 2'b00;
        census(40);
        check(ac[1], 4);
        check(ac[0], 0);
        check(act_run[1], 4);
        port_frame_pin <= 2'b01;
        repeat (12) @(posedge clock);
        census(80);
        check(ac[0], 40);
        port_frame_pin <= 2'b00;
        repeat (20) @(posedge clock);
        census(40);
        check(ac[0], 0);
        test_done;
    end
endmodule

`default_nettype wire
